// *** common/frx_pkg.sv ***
package frx_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int INSN_W = 14;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // opcode top-bit patterns of the 14-bit instruction word
  localparam logic [5:0] OPC_OR_FILE = 6'h04;
  localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
  localparam logic [6:0] OPC_STORE_ACC = 7'h01;
  localparam logic [3:0] OPC_LOAD_LIT = 4'hc;
  localparam logic [INSN_W-1:0] OPC_NOP = 14'h0000;
  localparam logic [INSN_W-1:0] NOP_MASK = 14'h3f9f;

  typedef enum logic [2:0] {
    FRX_OP_NONE,
    FRX_OP_OR_FILE,
    FRX_OP_MOVE_FILE,
    FRX_OP_STORE_ACC,
    FRX_OP_LOAD_LIT
  } frx_op_t;

  typedef struct packed {
    frx_op_t op;
    logic dest;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] lit;
  } frx_dec_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } frx_wr_t;
endpackage

// *** hdl/frx_decode.sv ***
`timescale 1ns/1ps
module frx_decode
  import frx_pkg::*;
(
  input wire logic [INSN_W-1:0] insn_i,
  output frx_dec_t dec_o
);
  always_comb begin
    dec_o.op = FRX_OP_NONE;
    dec_o.dest = insn_i[7];
    dec_o.addr = insn_i[6:0];
    dec_o.lit = insn_i[7:0];
    if (insn_i[13:8] == OPC_OR_FILE) begin
      dec_o.op = FRX_OP_OR_FILE;
    end else if (insn_i[13:8] == OPC_MOVE_FILE) begin
      dec_o.op = FRX_OP_MOVE_FILE;
    end else if (insn_i[13:7] == OPC_STORE_ACC) begin
      dec_o.op = FRX_OP_STORE_ACC;
    end else if (insn_i[13:10] == OPC_LOAD_LIT) begin
      dec_o.op = FRX_OP_LOAD_LIT;
    end
  end
endmodule

// *** hdl/frx_exec.sv ***
`timescale 1ns/1ps
module frx_exec
  import frx_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic insn_valid_i,
  input wire logic [INSN_W-1:0] insn_i,
  input wire logic [DATA_W-1:0] file_rdata_i,
  output logic [ADDR_W-1:0] file_raddr_o,
  output frx_wr_t file_wr_o,
  output logic [DATA_W-1:0] acc_o,
  output logic zero_o
);
  frx_dec_t dec;
  logic do_or;
  logic do_move;
  logic do_store;
  logic do_load;
  logic to_acc;
  logic to_file;
  logic [DATA_W-1:0] or_value;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] wdata_sel;
  logic result_zero;
  logic acc_load;
  logic zero_load;
  logic file_write;
  logic [DATA_W-1:0] acc_q;
  logic zero_q;
  logic we_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;

  frx_decode u_dec (
    .insn_i(insn_i),
    .dec_o(dec)
  );

  ////////////////////////////////////////////////////////////////////////
  // file read address is combinational so the whole op is one cycle
  assign file_raddr_o = dec.addr;

  ////////////////////////////////////////////////////////////////////////
  // one strobe per instruction class, only on a valid edge
  always_comb begin
    do_or = 1'b0;
    do_move = 1'b0;
    do_store = 1'b0;
    do_load = 1'b0;
    if (insn_valid_i) begin
      case (dec.op)
        FRX_OP_OR_FILE: begin
          do_or = 1'b1;
        end
        FRX_OP_MOVE_FILE: begin
          do_move = 1'b1;
        end
        FRX_OP_STORE_ACC: begin
          do_store = 1'b1;
        end
        FRX_OP_LOAD_LIT: begin
          do_load = 1'b1;
        end
        default: begin
          do_or = 1'b0;
        end
      endcase
    end
  end

  // destination selector
  always_comb begin
    to_acc = 1'b0;
    to_file = 1'b0;
    if (dec.dest == DEST_FILE) begin
      to_file = 1'b1;
    end else begin
      to_acc = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data path
  assign or_value = acc_q | file_rdata_i;

  always_comb begin
    result = acc_q;
    case (dec.op)
      FRX_OP_OR_FILE: begin
        result = or_value;
      end
      FRX_OP_MOVE_FILE: begin
        result = file_rdata_i;
      end
      FRX_OP_STORE_ACC: begin
        result = acc_q;
      end
      FRX_OP_LOAD_LIT: begin
        result = dec.lit;
      end
      default: begin
        result = acc_q;
      end
    endcase
  end

  // zero test of whatever the instruction produced
  always_comb begin
    result_zero = 1'b0;
    if (result == '0) begin
      result_zero = 1'b1;
    end
  end

  // value offered to the file write port
  always_comb begin
    wdata_sel = acc_q;
    if (do_or) begin
      wdata_sel = or_value;
    end
    if (do_move) begin
      wdata_sel = file_rdata_i;
    end
    if (do_store) begin
      wdata_sel = acc_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // update enables
  always_comb begin
    acc_load = 1'b0;
    if (do_or && to_acc) begin
      acc_load = 1'b1;
    end
    if (do_move && to_acc) begin
      acc_load = 1'b1;
    end
    if (do_load) begin
      acc_load = 1'b1;
    end
  end

  always_comb begin
    zero_load = 1'b0;
    if (do_or) begin
      zero_load = 1'b1;
    end
    if (do_move) begin
      zero_load = 1'b1;
    end
  end

  always_comb begin
    file_write = 1'b0;
    if (do_or && to_file) begin
      file_write = 1'b1;
    end
    if (do_move && to_file) begin
      file_write = 1'b1;
    end
    if (do_store) begin
      file_write = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      acc_q <= ACC_RST;
    end else if (acc_load) begin
      acc_q <= result;
    end
  end

  // zero flag; store, load and no-op leave it alone
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      zero_q <= ZERO_RST;
    end else if (zero_load) begin
      zero_q <= result_zero;
    end
  end

  // write strobe, a one-cycle pulse
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      we_q <= 1'b0;
    end else begin
      we_q <= file_write;
    end
  end

  // write address and data hold between writes, so the bus stays quiet
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      waddr_q <= '0;
    end else if (file_write) begin
      waddr_q <= dec.addr;
    end
  end

  // data only meaningful while the strobe is high
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wdata_q <= '0;
    end else if (file_write) begin
      wdata_q <= wdata_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign acc_o = acc_q;
  assign zero_o = zero_q;
  assign file_wr_o = '{we: we_q, addr: waddr_q, data: wdata_q};
endmodule

// *** dv/frx_chk.sv ***
`timescale 1ns/1ps
module frx_chk
  import frx_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic insn_valid_i,
  input wire logic zero_o,
  input wire logic [INSN_W-1:0] insn_i,
  input wire logic [DATA_W-1:0] file_rdata_i,
  input wire logic [DATA_W-1:0] acc_o,
  input frx_wr_t file_wr_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [23:0] p;
  wire [7:0] o = p[15:8] | p[7:0];
  wire [5:0] c = insn_valid_i ? insn_i[13:8] : 6'h3f;
  always_ff @(posedge clock_i) p <= {insn_i[7:0], acc_o, file_rdata_i};
  a_or_zero: assert property (c == 6'h04 |=> zero_o == !o)
    else $error("or zero");
  a_or_dest: assert property (c == 6'h04 |=> (p[23] ?
    file_wr_o == {1'b1, p[22:16], o} : acc_o == o)) else $error("or dest");
  a_move_dest: assert property (c == 6'h08 |=> (p[23] ?
    file_wr_o == {1'b1, p[22:16], p[7:0]} : acc_o == p[7:0]))
    else $error("move dest");
  a_move_zero: assert property (c == 6'h08 |=> zero_o == !p[7:0])
    else $error("move zero");
  a_store_acc: assert property (c == 6'h00 && insn_i[7] |=>
    file_wr_o == {1'b1, p[22:16], p[15:8]} && $stable(zero_o))
    else $error("store");
  a_load_lit: assert property (c[5:2] == 4'hc |=>
    acc_o == p[23:16] && $stable(zero_o)) else $error("load");
  a_nop_quiet: assert property ((c == 6'h3f || c == 6'h07 ||
    insn_i == 0) |=> !file_wr_o.we && $stable(acc_o) && $stable(zero_o))
    else $error("quiet");
endmodule
bind frx_exec frx_chk u_chk (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .insn_valid_i(insn_valid_i),
  .zero_o(zero_o),
  .insn_i(insn_i),
  .file_rdata_i(file_rdata_i),
  .acc_o(acc_o),
  .file_wr_o(file_wr_o)
);

// *** dv/frx_file_model.sv ***
`timescale 1ns/1ps
module frx_file_model import frx_pkg::*; (
  input wire logic clock_i,
  input frx_wr_t wr_i,
  input wire logic [6:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [128];
  initial foreach (mem[i]) mem[i] = 8'(i * 3) & {8{i[0]}};
  always @(posedge clock_i) if (wr_i.we) mem[wr_i.addr] <= wr_i.data;
  // write in flight forwarded to a read of the same place
  assign rdata_o = wr_i.we && wr_i.addr == raddr_i ? wr_i.data : mem[raddr_i];
endmodule

// *** dv/frx_exec_tb_top.sv ***
`timescale 1ns/1ps
module frx_exec_tb_top;
  import frx_pkg::*;
  logic clock_i = 0, rst_i = 1, insn_valid_i = 0, zero_o, ez = 0;
  logic [13:0] insn_i = 0;
  logic [7:0] file_rdata_i, acc_o, ea = 0, r, m [128];
  logic [6:0] file_raddr_o, a = 0;
  logic [31:0] l = 81718;
  frx_wr_t file_wr_o, ew = 0;
  int failures = 0, n_checks = 0;
  frx_exec dut (.clock_i(clock_i), .rst_i(rst_i), .insn_valid_i(insn_valid_i),
    .insn_i(insn_i), .file_rdata_i(file_rdata_i), .file_raddr_o(file_raddr_o),
    .file_wr_o(file_wr_o), .acc_o(acc_o), .zero_o(zero_o));
  frx_file_model fm (.clock_i(clock_i), .wr_i(file_wr_o),
    .raddr_i(file_raddr_o), .rdata_o(file_rdata_i));
  task report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(string n, logic [24:0] s, e);
    n_checks++;
    if (s !== e) failures++;
    if (s !== e) $display("wrong value %s exp %h seen %h", n, e, s);
  endtask
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  initial forever #5 clock_i = ~clock_i;
  initial begin
    #((12 + 400) * 10 * 2) failures++;
    report_and_stop;
  end
  initial begin
    foreach (m[i]) m[i] = 8'(i * 3) & {8{i[0]}};
    repeat (12) @(posedge clock_i);
    for (int k = 0; k < 400; k++) begin
      #1 rst_i = 0;
      chk("acc", acc_o, ea);
      chk("zero", zero_o, ez);
      chk("write enable", file_wr_o.we, ew.we);
      if (ew.we) chk("write", file_wr_o, ew);
      chk("read address", file_raddr_o, a);
      l = lfsr(l);
      insn_valid_i = |l[6:5];
      case (l[1:0])
        0: insn_i = {OPC_OR_FILE, l[14:7]};
        1: insn_i = {OPC_MOVE_FILE, l[14:7]};
        2: insn_i = {OPC_STORE_ACC, l[13:7]};
        3: insn_i = {OPC_LOAD_LIT, l[16:7]};
      endcase
      if (l[4:2] == 0) insn_i = OPC_NOP;
      // an opcode outside this group must do nothing
      if (l[4:2] == 1) insn_i = {6'h07, l[14:7]};
      a = insn_i[6:0];
      r = m[a] | (insn_i[13:8] == OPC_OR_FILE ? ea : 8'h00);
      ew = 0;
      if (k == 200) begin
        rst_i = 1;
        ea = 0;
        ez = 0;
      end else if (insn_valid_i) begin
        if (insn_i[13:7] == OPC_STORE_ACC) ew = {1'b1, a, ea};
        if (insn_i[13:10] == OPC_LOAD_LIT) ea = insn_i[7:0];
        if (insn_i[13:8] inside {OPC_OR_FILE, OPC_MOVE_FILE}) begin
          ez = r == 0;
          if (insn_i[7]) ew = {1'b1, a, r};
          else ea = r;
        end
      end
      if (ew.we) m[a] = ew.data;
      @(posedge clock_i);
    end
    $display("random instruction run done");
    report_and_stop;
  end
endmodule
